/* File: core/ulms_regs.sv */
// Line status, modem status, scratch and level-count register slice
// Summary of operation
// - Infrared enable routes serial data through IrDA coding; encoded transmit idles low.
// - Prescaler bit clear feeds baud generator undivided; set divides by four.
// - Data ready flag shows while any received character waits.
// - Character arriving with FIFO full sets overrun and is not stored.
// - Parity error flag belongs to the character at the read position.
// - Framing error flag belongs to the character at the read position.
// - Break flags the character; only one break character enters the FIFO.
// - Holding-empty flag shows empty holding register or empty transmit FIFO.
// - Transmitter-idle flag needs both holding side and shifter empty.
// - In FIFO mode, FIFO error flag stays set while any stored byte carries an error.
// - Clear-to-send, data-set-ready, carrier-detect changes set deltas; raise modem interrupt.
// - Ring delta sets only when ring input goes low to high.
// - Auto clear-to-send: high input halts after current character, low resumes.
// - Outside loopback, upper status bits are inverted modem input pins.
// - In loopback, upper status bits mirror modem control output bits.
// - Scratch holds host data and resets to all ones.
// - With swap set, scratch-location writes load the enhanced mode select.
// - Mode field picks receive, transmit or alternating level count.
// - Alternating mode reads receive count first, then transmit, repeating.
// - With swap set, scratch-location reads return the FIFO level count.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module ulms_regs (
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Modem pins
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ring_in_n,
  input  wire logic        carrier_detect_n,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             op2_n,
  output logic             msi_irq,
  // Receiver core
  input  wire logic        fifo_mode,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_parity_err,
  input  wire logic        rx_framing_err,
  input  wire logic        rx_break_det,
  input  wire logic        rx_line_high,
  // Transmitter core
  input  wire logic [6:0]  tx_fifo_count,
  input  wire logic        tx_shifter_busy,
  input  wire logic        tx_char_done,
  output logic             tx_halt,
  // Serial path and baud clocking
  input  wire logic        baud16_tick,
  input  wire logic        tx_serial,
  output logic             tx_pin,
  input  wire logic        rx_pin,
  output logic             rx_serial,
  output logic             baud_clk_en
);

  typedef struct packed {
    logic [7:0]                                 interrupt_enable_reg;
    logic [7:0]                                 modem_line_control;
    logic [7:0]                                 scr;
    logic [7:0]                                 feature_control;
    logic [7:0]                                 enhanced_feature_reg;
    logic [1:0]                                 lvl_mode;
    logic                                       alt_tx;
    logic [ulms_pkg::RXF_DEPTH-1:0][ulms_pkg::ENT_W-1:0] mem;
    logic [ulms_pkg::RXF_AW-1:0]                wr_ptr;
    logic [ulms_pkg::RXF_AW-1:0]                rd_ptr;
    logic [6:0]                                 rx_cnt;
    logic [6:0]                                 err_cnt;
    logic                                       overrun;
    logic                                       brk_held;
    logic [3:0]                                 delta;
    logic                                       halt;
    logic [1:0]                                 presc;
    logic [3:0]                                 ir_tx_ph;
    logic                                       ir_tx_prev;
    logic [4:0]                                 ir_rx_cnt;
    logic                                       ack;
    logic                                       err;
    logic [7:0]                                 rdata;
  } ulms_state_t;

  ulms_state_t q_ff;
  ulms_state_t nxt_q;

  logic [7:0]               msr_lvl;
  logic [3:0]               delta_ev;
  logic [7:0]               lsr_val;
  logic [7:0]               rd_val;
  logic                     hit;
  logic                     swap;
  logic                     loop;
  logic [ulms_pkg::ENT_W-1:0] top;
  logic [ulms_pkg::ENT_W-1:0] entry;
  logic [6:0]               full_lvl;
  logic                     push_req;
  logic                     push;
  logic                     pop;
  logic                     done_rd;
  logic                     done_wr;
  logic                     lvl_tx;
  logic                     cts_high;
  logic                     ir_pulse;

  assign loop = q_ff.modem_line_control[ulms_pkg::MCR_LOOP];
  assign swap = q_ff.feature_control[ulms_pkg::FEATURE_CONTROL_SWAP];
  assign top  = q_ff.mem[q_ff.rd_ptr];

  always_comb begin
    if (loop) begin
      msr_lvl = {q_ff.modem_line_control[ulms_pkg::MCR_OP2], q_ff.modem_line_control[ulms_pkg::MCR_OP1],
                 q_ff.modem_line_control[ulms_pkg::MCR_DTR], q_ff.modem_line_control[ulms_pkg::MCR_RTS], 4'h0};
    end else begin
      msr_lvl = {~carrier_detect_n, ~ring_in_n, ~dsr_n, ~cts_n, 4'h0};
    end
  end

  ulms_delta #(.FALL_ONLY(1'b0)) u_d_cts (.clk(clk), .rstn(rstn), .lvl(msr_lvl[4]), .chg(delta_ev[0]));
  ulms_delta #(.FALL_ONLY(1'b0)) u_d_dsr (.clk(clk), .rstn(rstn), .lvl(msr_lvl[5]), .chg(delta_ev[1]));
  ulms_delta #(.FALL_ONLY(1'b1)) u_d_ri  (.clk(clk), .rstn(rstn), .lvl(msr_lvl[6]), .chg(delta_ev[2]));
  ulms_delta #(.FALL_ONLY(1'b0)) u_d_cd  (.clk(clk), .rstn(rstn), .lvl(msr_lvl[7]), .chg(delta_ev[3]));

  // Line status view
  always_comb begin
    lsr_val = 8'h00;
    lsr_val[ulms_pkg::LSR_DRDY] = (q_ff.rx_cnt != 7'h00);
    lsr_val[ulms_pkg::LSR_OVR]  = q_ff.overrun;
    lsr_val[ulms_pkg::LSR_PERR] = (q_ff.rx_cnt != 7'h00) & top[ulms_pkg::ENT_PERR];
    lsr_val[ulms_pkg::LSR_FERR] = (q_ff.rx_cnt != 7'h00) & top[ulms_pkg::ENT_FERR];
    lsr_val[ulms_pkg::LSR_BRK]  = (q_ff.rx_cnt != 7'h00) & top[ulms_pkg::ENT_BRK];
    lsr_val[ulms_pkg::LSR_THRE] = (tx_fifo_count == 7'h00);
    lsr_val[ulms_pkg::LSR_TEMT] = (tx_fifo_count == 7'h00) & ~tx_shifter_busy;
    lsr_val[ulms_pkg::LSR_FIFOERR] = fifo_mode & (q_ff.err_cnt != 7'h00);
  end

  assign lvl_tx = q_ff.lvl_mode[0] & (~q_ff.lvl_mode[1] | q_ff.alt_tx);

  always_comb begin
    hit    = 1'b1;
    rd_val = 8'h00;
    case (paddr)
      ulms_pkg::ADDR_IER: begin
        rd_val = q_ff.interrupt_enable_reg;
      end
      ulms_pkg::ADDR_MCR: begin
        rd_val = q_ff.modem_line_control;
      end
      ulms_pkg::ADDR_LSR: begin
        rd_val = lsr_val;
      end
      ulms_pkg::ADDR_MSR: begin
        rd_val = msr_lvl | {4'h0, q_ff.delta};
      end
      ulms_pkg::ADDR_SCRATCH: begin
        if (swap) begin
          rd_val = lvl_tx ? {1'b0, tx_fifo_count} : {1'b0, q_ff.rx_cnt};
        end else begin
          rd_val = q_ff.scr;
        end
      end
      ulms_pkg::ADDR_FEATURE_CONTROL: begin
        rd_val = q_ff.feature_control;
      end
      ulms_pkg::ADDR_EFR: begin
        rd_val = q_ff.enhanced_feature_reg;
      end
      ulms_pkg::ADDR_RHOLD: begin
        rd_val = top[7:0];
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Effects land on the edge where pready is sampled high
  assign done_rd = psel & penable & q_ff.ack & ~pwrite & ~q_ff.err;
  assign done_wr = psel & penable & q_ff.ack & pwrite & ~q_ff.err;

  assign full_lvl = fifo_mode ? ulms_pkg::RXF_FULL : ulms_pkg::RHR_FULL;
  assign pop      = done_rd & (paddr == ulms_pkg::ADDR_RHOLD) & (q_ff.rx_cnt != 7'h00);

  always_comb begin
    push_req = rx_char_valid | (rx_break_det & ~q_ff.brk_held);
    if (rx_break_det & ~q_ff.brk_held) begin
      entry = {1'b1, rx_framing_err, 1'b0, 8'h00};
    end else begin
      entry = {1'b0, rx_framing_err, rx_parity_err, rx_char_data};
    end
  end

  assign push = push_req & (q_ff.rx_cnt < full_lvl);

  assign cts_high = loop ? ~q_ff.modem_line_control[ulms_pkg::MCR_RTS] : cts_n;
  assign ir_pulse = rx_pin ^ q_ff.feature_control[ulms_pkg::FEATURE_CONTROL_IR_INV];

  always_comb begin
    nxt_q = q_ff;

    // APB: one wait state, read data captured before pready
    if (psel & penable & ~q_ff.ack) begin
      nxt_q.ack   = 1'b1;
      nxt_q.err   = ~hit;
      nxt_q.rdata = rd_val;
    end else begin
      nxt_q.ack = 1'b0;
    end

    if (done_wr) begin
      case (paddr)
        ulms_pkg::ADDR_IER: begin
          nxt_q.interrupt_enable_reg = pwdata[7:0];
        end
        ulms_pkg::ADDR_MCR: begin
          nxt_q.modem_line_control = pwdata[7:0];
        end
        ulms_pkg::ADDR_SCRATCH: begin
          if (swap) begin
            nxt_q.lvl_mode = pwdata[1:0];
            nxt_q.alt_tx   = 1'b0;
          end else begin
            nxt_q.scr = pwdata[7:0];
          end
        end
        ulms_pkg::ADDR_FEATURE_CONTROL: begin
          nxt_q.feature_control = pwdata[7:0];
        end
        ulms_pkg::ADDR_EFR: begin
          nxt_q.enhanced_feature_reg = pwdata[7:0];
        end
        default: begin
          nxt_q.interrupt_enable_reg = q_ff.interrupt_enable_reg;
        end
      endcase
    end

    if (done_rd & swap & (paddr == ulms_pkg::ADDR_SCRATCH) & (q_ff.lvl_mode == ulms_pkg::LVL_ALT)) begin
      nxt_q.alt_tx = ~q_ff.alt_tx;
    end

    // clear only what was read; new changes win
    if (done_rd & (paddr == ulms_pkg::ADDR_MSR)) begin
      nxt_q.delta = (q_ff.delta & ~q_ff.rdata[3:0]) | delta_ev;
    end else begin
      nxt_q.delta = q_ff.delta | delta_ev;
    end

    // Overrun clears on status read unless a new one arrives
    if (done_rd & (paddr == ulms_pkg::ADDR_LSR) & q_ff.rdata[ulms_pkg::LSR_OVR]) begin
      nxt_q.overrun = 1'b0;
    end
    if (push_req & ~push) begin
      nxt_q.overrun = 1'b1;
    end

    if (rx_break_det & ~q_ff.brk_held) begin
      nxt_q.brk_held = 1'b1;
    end else if (rx_line_high) begin
      nxt_q.brk_held = 1'b0;
    end

    if (push) begin
      nxt_q.mem[q_ff.wr_ptr] = entry;
      nxt_q.wr_ptr           = q_ff.wr_ptr + 6'h01;
    end
    if (pop) begin
      nxt_q.rd_ptr = q_ff.rd_ptr + 6'h01;
    end
    nxt_q.rx_cnt = q_ff.rx_cnt + {6'h00, push} - {6'h00, pop};

    nxt_q.err_cnt = q_ff.err_cnt + {6'h00, push & (|entry[ulms_pkg::ENT_BRK:ulms_pkg::ENT_PERR])}
                    - {6'h00, pop & (|top[ulms_pkg::ENT_BRK:ulms_pkg::ENT_PERR])};

    if (~q_ff.enhanced_feature_reg[ulms_pkg::EFR_AUTO_CTS] | ~cts_high) begin
      nxt_q.halt = 1'b0;
    end else if (~tx_shifter_busy | tx_char_done) begin
      nxt_q.halt = 1'b1;
    end

    nxt_q.presc = q_ff.presc + 2'h1;

    // IrDA transmit phase restarts at each data edge
    nxt_q.ir_tx_prev = tx_serial;
    if (tx_serial != q_ff.ir_tx_prev) begin
      nxt_q.ir_tx_ph = 4'h0;
    end else if (baud16_tick) begin
      nxt_q.ir_tx_ph = q_ff.ir_tx_ph + 4'h1;
    end

    // IrDA receive pulse stretched to one bit time
    if (ir_pulse) begin
      nxt_q.ir_rx_cnt = ulms_pkg::IR_BIT_TK;
    end else if (baud16_tick & (q_ff.ir_rx_cnt != 5'h00)) begin
      nxt_q.ir_rx_cnt = q_ff.ir_rx_cnt - 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_ff     <= '0;
      q_ff.scr <= ulms_pkg::SCRATCH_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign prdata  = {24'h000000, q_ff.rdata};
  assign pready  = q_ff.ack;
  assign pslverr = q_ff.ack & q_ff.err;

  // Modem outputs held inactive during loopback
  assign dtr_n = loop | ~q_ff.modem_line_control[ulms_pkg::MCR_DTR];
  assign rts_n = loop | ~q_ff.modem_line_control[ulms_pkg::MCR_RTS];
  assign op2_n = loop | ~q_ff.modem_line_control[ulms_pkg::MCR_OP2];

  assign msi_irq = q_ff.interrupt_enable_reg[ulms_pkg::IER_MSI] & (|q_ff.delta);

  assign tx_halt = q_ff.halt;

  assign baud_clk_en = ~q_ff.modem_line_control[ulms_pkg::MCR_PRESC] | (q_ff.presc == ulms_pkg::PRESC_LAST);

  always_comb begin
    if (loop) begin
      tx_pin    = ~q_ff.modem_line_control[ulms_pkg::MCR_IR_EN];
      rx_serial = tx_serial;
    end else if (q_ff.modem_line_control[ulms_pkg::MCR_IR_EN]) begin
      tx_pin    = ~tx_serial & (q_ff.ir_tx_ph < ulms_pkg::IR_PULSE_TK);
      rx_serial = ~(ir_pulse | (q_ff.ir_rx_cnt != 5'h00));
    end else begin
      tx_pin    = tx_serial;
      rx_serial = rx_pin;
    end
  end

endmodule

/* File: core/ulms_pkg.sv */
// Shared constants for the UART line and modem status register slice
package ulms_pkg;

  // APB byte addresses, one aligned word each
  localparam logic [7:0] ADDR_IER      = 8'h00;
  localparam logic [7:0] ADDR_MCR      = 8'h04;
  localparam logic [7:0] ADDR_LSR      = 8'h08;
  localparam logic [7:0] ADDR_MSR      = 8'h0C;
  localparam logic [7:0] ADDR_SCRATCH  = 8'h10;
  localparam logic [7:0] ADDR_FEATURE_CONTROL     = 8'h14;
  localparam logic [7:0] ADDR_EFR      = 8'h18;
  localparam logic [7:0] ADDR_RHOLD    = 8'h1C;

  // modem_line_control fields
  localparam int MCR_DTR      = 0;
  localparam int MCR_RTS      = 1;
  localparam int MCR_OP1      = 2;
  localparam int MCR_OP2      = 3;
  localparam int MCR_LOOP     = 4;
  localparam int MCR_IR_EN    = 6;
  localparam int MCR_PRESC    = 7;

  // line_status fields
  localparam int LSR_DRDY     = 0;
  localparam int LSR_OVR      = 1;
  localparam int LSR_PERR     = 2;
  localparam int LSR_FERR     = 3;
  localparam int LSR_BRK      = 4;
  localparam int LSR_THRE     = 5;
  localparam int LSR_TEMT     = 6;
  localparam int LSR_FIFOERR  = 7;

  // Other control fields
  localparam int IER_MSI      = 3;
  localparam int FEATURE_CONTROL_IR_INV  = 2;
  localparam int FEATURE_CONTROL_SWAP    = 6;
  localparam int EFR_AUTO_CTS = 7;

  // Receive entry layout: data, parity, framing, break
  localparam int ENT_PERR     = 8;
  localparam int ENT_FERR     = 9;
  localparam int ENT_BRK      = 10;
  localparam int ENT_W        = 11;

  // Reset values
  localparam logic [7:0] SCRATCH_RST = 8'hFF;
  localparam logic [7:0] REG_RST     = 8'h00;

  // Receive FIFO geometry
  localparam int         RXF_DEPTH   = 64;
  localparam int         RXF_AW      = 6;
  localparam logic [6:0] RXF_FULL    = 7'h40;
  localparam logic [6:0] RHR_FULL    = 7'h01;

  // Prescaler count in clock cycles; IrDA timing in baud16 ticks
  localparam logic [1:0] PRESC_LAST  = 2'h3;
  localparam logic [3:0] IR_PULSE_TK = 4'h3;
  localparam logic [4:0] IR_BIT_TK   = 5'h10;

  // Level counter mode encodings of enhanced_mode_select[1:0]
  localparam logic [1:0] LVL_ALT     = 2'h3;

endpackage

/* File: core/ulms_delta.sv */
// Change detector for one modem status level bit
`timescale 1ns/100ps
module ulms_delta #(
  parameter bit FALL_ONLY = 1'b0
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic lvl,
  output logic      chg
);

  typedef struct packed {
    logic prev;
  } ulms_delta_t;

  ulms_delta_t q_ff;
  ulms_delta_t nxt_q;

  always_comb begin
    nxt_q      = q_ff;
    nxt_q.prev = lvl;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Fall-only variant reports only the end of a ring
  assign chg = FALL_ONLY ? (q_ff.prev & ~lvl) : (q_ff.prev ^ lvl);

endmodule

/* File: bench/ulms_regs_chk.sv */
// Port-level checker for the register slice
`timescale 1ns/100ps
module ulms_regs_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cts_n,
  input wire logic        dsr_n,
  input wire logic        ring_in_n,
  input wire logic        carrier_detect_n,
  input wire logic        msi_irq,
  input wire logic        tx_shifter_busy,
  input wire logic        tx_char_done,
  input wire logic        tx_halt,
  input wire logic        baud_clk_en
);
  logic [3:0] pins;
  logic [3:0] pins_ff;
  logic [3:0] quiet_ff;
  assign pins = {cts_n, dsr_n, ring_in_n, carrier_detect_n};
  // Quiet time since any pin change or write; a late delta may legally re-arm
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins_ff  <= 4'h0;
      quiet_ff <= 4'h0;
    end else begin
      pins_ff <= pins;
      if ((psel && pwrite) || (pins != pins_ff)) begin
        quiet_ff <= 4'h0;
      end else if (quiet_ff != 4'hF) begin
        quiet_ff <= quiet_ff + 4'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_apb_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_single: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access or held too long");
  a_err_unmapped: assert property (pready && paddr > 8'h1C |-> pslverr)
    else $error("unmapped access not refused");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_halt_release: assert property (!cts_n |=> !tx_halt)
    else $error("halt kept with clear-to-send low");
  a_halt_cause: assert property ($rose(tx_halt) |-> $past(cts_n) && (!$past(tx_shifter_busy) || $past(tx_char_done)))
    else $error("halt set mid character or without request");
  a_presc_gap: assert property ($rose(baud_clk_en) |=> !baud_clk_en [*3])
    else $error("divided baud enable too frequent");
  a_msr_read_clears: assert property (pready && !pwrite && paddr == ulms_pkg::ADDR_MSR && quiet_ff >= 4'h6 |=> !msi_irq)
    else $error("modem interrupt survives status read");
  c_refused: cover property (pready && pslverr);
  c_halt: cover property ($rose(tx_halt));
  c_msi: cover property ($rose(msi_irq));
endmodule

bind ulms_regs ulms_regs_chk u_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(cts_n), .dsr_n(dsr_n),
  .ring_in_n(ring_in_n), .carrier_detect_n(carrier_detect_n), .msi_irq(msi_irq),
  .tx_shifter_busy(tx_shifter_busy), .tx_char_done(tx_char_done), .tx_halt(tx_halt), .baud_clk_en(baud_clk_en));

/* File: bench/ulms_modem.sv */
// Modem and remote line model facing the register slice
`timescale 1ns/100ps
module ulms_modem (
  input  wire logic clk,
  output logic      cts_n,
  output logic      dsr_n,
  output logic      ring_in_n,
  output logic      carrier_detect_n,
  output logic      rx_pin
);
  // Lines inactive and receive line at mark until told otherwise
  initial begin
    {cts_n, dsr_n, ring_in_n, carrier_detect_n} = 4'hF;
    rx_pin = 1'b1;
  end
  // Order cts, dsr, ring, carrier; waits out the single-stage change detect
  task drive(input logic [3:0] lv);
    @(posedge clk);
    {cts_n, dsr_n, ring_in_n, carrier_detect_n} <= lv;
    repeat (5) @(posedge clk);
  endtask
  // Receive line level, one change per call, just after an edge
  task line(input logic v);
    @(posedge clk);
    rx_pin <= v;
  endtask
endmodule

/* File: bench/uart_line_modem_status_regs_tb.sv */
// Self-checking bench for the line and modem status register slice
`timescale 1ns/100ps
module uart_line_modem_status_regs_tb;
  localparam logic [7:0] A_MCR = ulms_pkg::ADDR_MCR;
  localparam logic [7:0] A_LSR = ulms_pkg::ADDR_LSR;
  localparam logic [7:0] A_MSR = ulms_pkg::ADDR_MSR;
  localparam logic [7:0] A_SCR = ulms_pkg::ADDR_SCRATCH;
  localparam logic [7:0] A_RHD = ulms_pkg::ADDR_RHOLD;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic        fifo_mode, rx_char_valid, rx_parity_err, rx_framing_err, rx_break_det, rx_line_high;
  logic        tx_shifter_busy, tx_char_done, tx_halt, baud16_tick, tx_serial, tx_pin, rx_pin, rx_serial;
  logic        cts_n, dsr_n, ring_in_n, carrier_detect_n, dtr_n, rts_n, op2_n, msi_irq, baud_clk_en;
  logic [7:0]  paddr, rx_char_data;
  logic [6:0]  tx_fifo_count;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count, compares, cyc, i, n;

  ulms_regs uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(cts_n), .dsr_n(dsr_n),
    .ring_in_n(ring_in_n), .carrier_detect_n(carrier_detect_n), .dtr_n(dtr_n), .rts_n(rts_n), .op2_n(op2_n),
    .msi_irq(msi_irq), .fifo_mode(fifo_mode), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err), .rx_break_det(rx_break_det),
    .rx_line_high(rx_line_high), .tx_fifo_count(tx_fifo_count), .tx_shifter_busy(tx_shifter_busy),
    .tx_char_done(tx_char_done), .tx_halt(tx_halt), .baud16_tick(baud16_tick), .tx_serial(tx_serial),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .rx_serial(rx_serial), .baud_clk_en(baud_clk_en));
  ulms_modem m (.clk(clk), .cts_n(cts_n), .dsr_n(dsr_n), .ring_in_n(ring_in_n),
    .carrier_detect_n(carrier_detect_n), .rx_pin(rx_pin));

  always #5 clk = ~clk;
  // Whole run needs under 2000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  task end_sim;
    $display("compares=%0d mismatches=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wt(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Idle cycle first so a released strobe is never re-raised in the same step
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int c;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (pready !== 1'b1 && c < 20);
    if (c >= 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task push(input logic [7:0] d, input logic pe, input logic fe);
    @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_parity_err <= pe;
    rx_framing_err <= fe;
    @(posedge clk);
    rx_char_valid <= 1'b0;
  endtask
  task brk;
    @(posedge clk);
    rx_break_det <= 1'b1;
    @(posedge clk);
    rx_break_det <= 1'b0;
  endtask

  task t_reset;
    rdc(A_SCR, 8'hFF);
    rdc(A_LSR, 8'h60);
    rdc(A_MSR, 8'h00);
    apb(1'b0, 8'h40, 8'h00);
    chk({31'h0, err}, 32'h1);
    $display("reset test done");
  endtask
  task t_tx;
    tx_fifo_count <= 7'h03;
    tx_shifter_busy <= 1'b1;
    rdc(A_LSR, 8'h00);
    tx_fifo_count <= 7'h00;
    rdc(A_LSR, 8'h20);
    tx_shifter_busy <= 1'b0;
    rdc(A_LSR, 8'h60);
    $display("tx test done");
  endtask
  task t_rx;
    push(8'hA5, 1'b1, 1'b0);
    push(8'h3C, 1'b0, 1'b0);
    rdc(A_LSR, 8'h67);
    rdc(A_RHD, 8'hA5);
    rdc(A_LSR, 8'h60);
    fifo_mode <= 1'b1;
    push(8'h11, 1'b0, 1'b1);
    push(8'h22, 1'b0, 1'b0);
    rdc(A_LSR, 8'hE9);
    rdc(A_RHD, 8'h11);
    rdc(A_LSR, 8'h61);
    rdc(A_RHD, 8'h22);
    brk();
    brk();
    rdc(A_LSR, 8'hF1);
    rdc(A_RHD, 8'h00);
    rdc(A_LSR, 8'h60);
    rx_line_high <= 1'b1;
    for (i = 0; i < 65; i++) push(i[7:0], 1'b0, 1'b0);
    rdc(A_LSR, 8'h63);
    for (i = 0; i < 64; i++) rdc(A_RHD, i[7:0]);
    rdc(A_LSR, 8'h60);
    $display("rx test done");
  endtask
  task t_modem;
    wr(ulms_pkg::ADDR_IER, 8'h08);
    m.drive(4'b0111);
    chk({31'h0, msi_irq}, 32'h1);
    rdc(A_MSR, 8'h11);
    wt(2);
    chk({31'h0, msi_irq}, 32'h0);
    rdc(A_MSR, 8'h10);
    m.drive(4'b0101);
    chk({31'h0, msi_irq}, 32'h0);
    rdc(A_MSR, 8'h50);
    m.drive(4'b0111);
    rdc(A_MSR, 8'h14);
    m.drive(4'b0010);
    rdc(A_MSR, 8'hBA);
    m.drive(4'b1111);
    rdc(A_MSR, 8'h0B);
    $display("modem test done");
  endtask
  task t_loop;
    wr(A_MCR, 8'h0B);
    // Write lands on the edge the task returns at
    wt(1);
    chk({29'h0, dtr_n, rts_n, op2_n}, 32'h0);
    wr(A_MCR, 8'h1D);
    wt(5);
    chk({29'h0, dtr_n, rts_n, op2_n}, 32'h7);
    rdc(A_MSR, 8'hEA);
    wr(A_MCR, 8'h10);
    wt(5);
    rdc(A_MSR, 8'h0E);
    wr(A_MCR, 8'h00);
    $display("loopback test done");
  endtask
  task t_halt;
    wr(ulms_pkg::ADDR_EFR, 8'h80);
    wt(3);
    chk({31'h0, tx_halt}, 32'h1);
    m.drive(4'b0111);
    chk({31'h0, tx_halt}, 32'h0);
    tx_shifter_busy <= 1'b1;
    m.drive(4'b1111);
    chk({31'h0, tx_halt}, 32'h0);
    @(posedge clk);
    tx_char_done <= 1'b1;
    @(posedge clk);
    tx_char_done <= 1'b0;
    wt(1);
    chk({31'h0, tx_halt}, 32'h1);
    tx_shifter_busy <= 1'b0;
    wr(ulms_pkg::ADDR_EFR, 8'h00);
    m.drive(4'b0111);
    $display("halt test done");
  endtask
  task t_swap;
    wr(A_SCR, 8'h5A);
    rdc(A_SCR, 8'h5A);
    push(8'h01, 1'b0, 1'b0);
    push(8'h02, 1'b0, 1'b0);
    tx_fifo_count <= 7'h05;
    wr(ulms_pkg::ADDR_FEATURE_CONTROL, 8'h40);
    wr(A_SCR, 8'h00);
    rdc(A_SCR, 8'h02);
    wr(A_SCR, 8'h01);
    rdc(A_SCR, 8'h05);
    wr(A_SCR, 8'h02);
    rdc(A_SCR, 8'h02);
    wr(A_SCR, 8'h03);
    for (i = 0; i < 3; i++) rdc(A_SCR, i[0] ? 8'h05 : 8'h02);
    wr(ulms_pkg::ADDR_FEATURE_CONTROL, 8'h00);
    rdc(A_SCR, 8'h5A);
    tx_fifo_count <= 7'h00;
    $display("swap test done");
  endtask
  task t_irda;
    wr(A_MCR, 8'h40);
    // Encoded receive idles low; let the stretch counter drain
    m.line(1'b0);
    baud16_tick <= 1'b1;
    wt(20);
    chk({31'h0, rx_serial}, 32'h1);
    @(posedge clk);
    tx_serial <= 1'b0;
    @(posedge clk);
    n = 0;
    repeat (8) begin
      @(posedge clk);
      n += tx_pin;
    end
    chk(32'(n), 32'(ulms_pkg::IR_PULSE_TK));
    tx_serial <= 1'b1;
    m.line(1'b1);
    m.line(1'b0);
    n = 0;
    repeat (24) begin
      @(posedge clk);
      n += !rx_serial;
    end
    chk(32'(n), 32'(ulms_pkg::IR_BIT_TK));
    wt(1);
    chk({31'h0, tx_pin}, 32'h0);
    wr(A_MCR, 8'h00);
    m.line(1'b1);
    wt(1);
    chk({31'h0, rx_serial}, 32'h1);
    baud16_tick <= 1'b0;
    $display("irda test done");
  endtask
  task t_clocking;
    wr(A_MCR, 8'h40);
    wt(1);
    chk({31'h0, tx_pin}, 32'h0);
    wr(A_MCR, 8'h80);
    n = 0;
    repeat (16) begin
      @(posedge clk);
      n += baud_clk_en;
    end
    chk(32'(n), 32'h4);
    rstn <= 1'b0;
    wt(3);
    rstn <= 1'b1;
    rdc(A_SCR, 8'hFF);
    wt(1);
    chk({31'h0, baud_clk_en}, 32'h1);
    $display("clocking test done");
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fifo_mode, rx_char_valid, rx_char_data, rx_parity_err, rx_framing_err, rx_break_det, rx_line_high} = '0;
    {tx_fifo_count, tx_shifter_busy, tx_char_done, baud16_tick} = '0;
    tx_serial = 1'b1;
    fail_count = 0;
    compares = 0;
    cyc = 0;
    wt(3);
    rstn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_modem();
    t_loop();
    t_halt();
    t_swap();
    t_irda();
    t_clocking();
    end_sim();
  end
endmodule
